// ==== logic/ebbs_cfg.svh ====
`ifndef EBBS_CFG_SVH
`define EBBS_CFG_SVH

// ******************************************
// control register layout and reset
// ******************************************
`define EBBS_CTL_W 16
`define EBBS_CTL_RESET 16'hF800
`define EBBS_CTL_WMASK 16'hF905
`define EBBS_BNK_HI 15
`define EBBS_BNK_LO 12
`define EBBS_TURN_BIT 11
`define EBBS_IPI_BIT 8
`define EBBS_KEEP_BIT 2
`define EBBS_OFF_BIT 0

// ******************************************
// apb byte addresses
// ******************************************
`define EBBS_AW 12
`define EBBS_ADR_CTLA 12'h000
`define EBBS_ADR_CTLB 12'h004
`define EBBS_ADR_STAT 12'h008
`define EBBS_ADR_CLR 12'h00C
`define EBBS_ADR_IEN 12'h010

// ******************************************
// event bits of status, clear and enable
// ******************************************
`define EBBS_EV_W 3
`define EBBS_EV_IPIA 0
`define EBBS_EV_IPIB 1
`define EBBS_EV_OFF 2

// ******************************************
// bus widths
// ******************************************
`define EBBS_ADDR_W 16
`define EBBS_PAGE_W 8
`define EBBS_BANK_W 4

`endif

// ==== logic/ebbs_pkg.sv ====
`include "ebbs_cfg.svh"
package ebbs_pkg;
   // bus sequencer states, gray along idle-gap-cycle
   typedef enum logic [1:0] {
      EBBS_IDLE = 2'h0,
      EBBS_GAP = 2'h1,
      EBBS_CYCLE = 2'h3,
      EBBS_OFF = 2'h2
   } ebbs_state_t;

   // address space of an external access
   typedef enum logic [1:0] {
      EBBS_SP_PROG = 2'h0,
      EBBS_SP_DATA = 2'h1,
      EBBS_SP_IO = 2'h2
   } ebbs_space_t;

   // complete state of the controller
   typedef struct packed {
      ebbs_state_t state;
      logic [`EBBS_CTL_W-1:0] ctlA;
      logic [`EBBS_CTL_W-1:0] ctlB;
      logic [`EBBS_EV_W-1:0] status;
      logic [`EBBS_EV_W-1:0] irqEn;
      logic [31:0] prdata;
      logic [`EBBS_BANK_W-1:0] prevBankP;
      logic [`EBBS_BANK_W-1:0] prevBankD;
      logic prevValidP;
      logic prevValidD;
      logic [`EBBS_PAGE_W-1:0] prevPage;
      logic lastRead;
      logic lastReadProg;
      logic [`EBBS_ADDR_W-1:0] addr;
      logic [`EBBS_PAGE_W-1:0] page;
      logic progStrobeN;
      logic dataStrobeN;
      logic ioStrobeN;
      logic readStrobeN;
      logic writeStrobeN;
      logic [15:0] dataOut;
      logic dataOe;
      logic subsysSel;
      logic ipiToB;
      logic ipiToA;
      logic [15:0] keeperLevel;
   } ebbs_regs_t;
endpackage

// ==== logic/ebbs_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// two flop synchroniser for pin inputs
// ******************************************
module ebbs_sync2 #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_reg; // first stage, read only by dout

   // plain double register, reset to zero
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_reg <= '0;
         dout <= '0;
      end else begin
         meta_reg <= din;
         dout <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== logic/ebbs_bank_switch.sv ====
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ebbs_cfg.svh"
module ebbs_bank_switch (
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`EBBS_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // arbitration: high when subsystem b owns the bus
   input wire logic ownerB,
   // access request from the cores
   input wire logic reqValid,
   output logic reqReady,
   input wire ebbs_pkg::ebbs_space_t reqSpace,
   input wire logic reqRead,
   input wire logic [`EBBS_ADDR_W-1:0] reqAddr,
   input wire logic [`EBBS_PAGE_W-1:0] reqPage,
   input wire logic [15:0] reqWrData,
   input wire logic reqSubsys,
   // external bus
   output logic [`EBBS_ADDR_W-1:0] extAddr,
   output logic [`EBBS_PAGE_W-1:0] extPage,
   output logic progStrobeN,
   output logic dataStrobeN,
   output logic ioStrobeN,
   output logic readStrobeN,
   output logic writeStrobeN,
   output logic subsystemSelect,
   input wire logic [15:0] parallelDataPinsIn,
   output logic [15:0] parallelDataPinsOut,
   output logic parallelDataPinsOe,
   // bus keeper drive, weak in the pad
   output logic [15:0] keeperLevel,
   output logic keeperDrive,
   // mode bit write blocks per subsystem
   output logic modeLockA,
   output logic modeLockB,
   // interprocessor interrupt pulses and the level interrupt request
   output logic ipiToA,
   output logic ipiToB,
   output logic irq
);
   import ebbs_pkg::*;

   // ******************************************
   // helpers
   // ******************************************

   // mask a bank number with the current compare field, so a
   // change of bank size never counts as a crossing by itself
   function automatic logic [`EBBS_BANK_W-1:0] maskBank(
      input logic [`EBBS_BANK_W-1:0] b,
      input logic [`EBBS_CTL_W-1:0] ctl
   );
      maskBank = b & ctl[`EBBS_BNK_HI:`EBBS_BNK_LO];
   endfunction

   // masked bank number of an address
   function automatic logic [`EBBS_BANK_W-1:0] bankOf(
      input logic [`EBBS_ADDR_W-1:0] a,
      input logic [`EBBS_CTL_W-1:0] ctl
   );
      bankOf = maskBank(a[`EBBS_ADDR_W-1 -: `EBBS_BANK_W], ctl);
   endfunction

   // new value of a control copy after a write
   function automatic logic [`EBBS_CTL_W-1:0] ctlWrite(
      input logic [`EBBS_CTL_W-1:0] old,
      input logic [31:0] wd
   );
      // reserved bits keep their value
      ctlWrite = (old & ~`EBBS_CTL_WMASK) | (wd[`EBBS_CTL_W-1:0] & `EBBS_CTL_WMASK);
   endfunction

   // ******************************************
   // state
   // ******************************************
   ebbs_regs_t cur_reg; // registered state
   ebbs_regs_t cur_next; // next state
   logic [15:0] pinsSync; // synchronised data pins
   logic [`EBBS_CTL_W-1:0] govCtl; // governing copy
   logic [`EBBS_BANK_W-1:0] reqBank; // bank of request
   logic offNow; // bus off requested
   logic crossProg; // program bank or page crossing
   logic crossData; // data bank crossing
   logic turnNeed; // program/data read turnaround
   logic gapNeed; // any extra cycle needed
   logic canIssue; // sequencer may start a cycle
   logic accept; // request taken this cycle
   logic apbWrite; // apb write access phase
   logic apbSetup; // apb setup phase
   logic apbHit; // mapped address
   logic [`EBBS_EV_W-1:0] events; // event pulses this cycle

   // pins come from outside, two flops first
   ebbs_sync2 #(
      .W(16)
   ) u_pinSync (
      .clk(clk),
      .resetn(resetn),
      .din(parallelDataPinsIn),
      .dout(pinsSync)
   );
   // the keeper level thus lags the pins by three clocks

   // ******************************************
   // access decision
   // ******************************************

   // pick the copy of the arbitration winner
   always_comb begin
      govCtl = ownerB ? cur_reg.ctlB : cur_reg.ctlA;
      offNow = govCtl[`EBBS_OFF_BIT];
      reqBank = bankOf(reqAddr, govCtl);
   end

   // crossing and turnaround detection
   always_comb begin
      // program space: bank or page change
      crossProg = (reqSpace == EBBS_SP_PROG) && cur_reg.prevValidP &&
                  ((reqBank != maskBank(cur_reg.prevBankP, govCtl)) ||
                   (reqPage != cur_reg.prevPage));
      // data space: bank change only
      crossData = (reqSpace == EBBS_SP_DATA) && cur_reg.prevValidD &&
                  (reqBank != maskBank(cur_reg.prevBankD, govCtl));
      // read of one space after read of the other
      turnNeed = govCtl[`EBBS_TURN_BIT] && reqRead && cur_reg.lastRead &&
                 (reqSpace != EBBS_SP_IO) &&
                 (cur_reg.lastReadProg != (reqSpace == EBBS_SP_PROG));
      gapNeed = crossProg || crossData || turnNeed;
   end

   // handshake toward the cores; while the bus is off
   // every new request waits, the gap state excepted
   always_comb begin
      canIssue = ((cur_reg.state == EBBS_IDLE) || (cur_reg.state == EBBS_CYCLE)) && !offNow;
      // gap state always completes its held request
      accept = reqValid && ((cur_reg.state == EBBS_GAP) || (canIssue && !gapNeed));
      reqReady = accept;
   end

   // ******************************************
   // apb decode
   // ******************************************
   always_comb begin
      apbSetup = psel && !penable;
      apbWrite = psel && penable && pwrite;
      // every map entry is a single word
      apbHit = (paddr == `EBBS_ADR_CTLA) || (paddr == `EBBS_ADR_CTLB) ||
               (paddr == `EBBS_ADR_STAT) || (paddr == `EBBS_ADR_CLR) ||
               (paddr == `EBBS_ADR_IEN);
      // zero wait states: every access completes at once
      pready = 1'b1;
      pslverr = psel && penable && !apbHit;
   end

   // ******************************************
   // next state
   // ******************************************
   always_comb begin
      cur_next = cur_reg;
      events = '0;

      // register writes, taken in the access phase
      if (apbWrite) begin
         case (paddr)
            `EBBS_ADR_CTLA: begin
               cur_next.ctlA = ctlWrite(cur_reg.ctlA, pwdata);
            end
            `EBBS_ADR_CTLB: begin
               cur_next.ctlB = ctlWrite(cur_reg.ctlB, pwdata);
            end
            `EBBS_ADR_IEN: begin
               cur_next.irqEn = pwdata[`EBBS_EV_W-1:0];
            end
            default: begin
               // status read only, clear handled below
            end
         endcase
      end

      // a rising request bit sends one pulse, so a second
      // pulse needs the bit cleared and set again
      cur_next.ipiToB = !cur_reg.ctlA[`EBBS_IPI_BIT] && cur_next.ctlA[`EBBS_IPI_BIT];
      cur_next.ipiToA = !cur_reg.ctlB[`EBBS_IPI_BIT] && cur_next.ctlB[`EBBS_IPI_BIT];
      events[`EBBS_EV_IPIA] = cur_next.ipiToB;
      events[`EBBS_EV_IPIB] = cur_next.ipiToA;

      // read data latched in setup, shown in access
      if (apbSetup) begin
         case (paddr)
            `EBBS_ADR_CTLA: begin
               cur_next.prdata = {16'h0000, cur_reg.ctlA};
            end
            `EBBS_ADR_CTLB: begin
               cur_next.prdata = {16'h0000, cur_reg.ctlB};
            end
            `EBBS_ADR_STAT: begin
               cur_next.prdata = {29'h00000000, cur_reg.status};
            end
            `EBBS_ADR_IEN: begin
               cur_next.prdata = {29'h00000000, cur_reg.irqEn};
            end
            default: begin
               // clear register and unmapped read zero
               cur_next.prdata = 32'h00000000;
            end
         endcase
      end

      // sequencer; strobes inactive unless a cycle starts
      cur_next.progStrobeN = 1'b1;
      cur_next.dataStrobeN = 1'b1;
      cur_next.ioStrobeN = 1'b1;
      cur_next.readStrobeN = 1'b1;
      cur_next.writeStrobeN = 1'b1;
      cur_next.dataOe = 1'b0;
      case (cur_reg.state)
         EBBS_IDLE, EBBS_CYCLE: begin
            if (offNow) begin
               // the cycle in flight has now ended
               cur_next.state = EBBS_OFF;
               events[`EBBS_EV_OFF] = 1'b1;
            end else if (reqValid && gapNeed) begin
               // one idle bus cycle before the access
               cur_next.state = EBBS_GAP;
            end else if (accept) begin
               cur_next.state = EBBS_CYCLE;
            end else begin
               cur_next.state = EBBS_IDLE;
            end
         end
         EBBS_GAP: begin
            // the request held over the gap is taken now
            cur_next.state = reqValid ? EBBS_CYCLE : EBBS_IDLE;
         end
         EBBS_OFF: begin
            // address, data and strobes held inactive
            cur_next.addr = '0;
            cur_next.page = '0;
            // leave only when the governing copy clears the bit
            if (!offNow) begin
               cur_next.state = EBBS_IDLE;
            end
         end
         default: begin
            cur_next.state = EBBS_IDLE;
         end
      endcase

      // drive the new bus cycle
      if (accept) begin
         cur_next.addr = reqAddr;
         cur_next.page = reqPage;
         cur_next.progStrobeN = (reqSpace != EBBS_SP_PROG);
         cur_next.dataStrobeN = (reqSpace != EBBS_SP_DATA);
         // 64K word io space, own strobe
         cur_next.ioStrobeN = (reqSpace != EBBS_SP_IO);
         cur_next.readStrobeN = !reqRead;
         cur_next.writeStrobeN = reqRead;
         cur_next.dataOut = reqRead ? cur_reg.dataOut : reqWrData;
         cur_next.dataOe = !reqRead;
         // which subsystem makes the access
         cur_next.subsysSel = reqSubsys;
         // remember raw top bits per space for the next compare;
         // they are masked when compared, so a new size acts at once
         if (reqSpace == EBBS_SP_PROG) begin
            cur_next.prevBankP = reqAddr[`EBBS_ADDR_W-1 -: `EBBS_BANK_W];
            cur_next.prevPage = reqPage;
            cur_next.prevValidP = 1'b1;
         end else if (reqSpace == EBBS_SP_DATA) begin
            cur_next.prevBankD = reqAddr[`EBBS_ADDR_W-1 -: `EBBS_BANK_W];
            cur_next.prevValidD = 1'b1;
         end
         cur_next.lastRead = reqRead && (reqSpace != EBBS_SP_IO);
         cur_next.lastReadProg = (reqSpace == EBBS_SP_PROG);
      end

      // keeper level follows the synchronised pins every cycle
      cur_next.keeperLevel = pinsSync;

      // sticky status, a new event beats the clear
      // clear register drops the bits written as ones
      if (apbWrite && (paddr == `EBBS_ADR_CLR)) begin
         cur_next.status = (cur_reg.status & ~pwdata[`EBBS_EV_W-1:0]) | events;
      end else begin
         cur_next.status = cur_reg.status | events;
      end
   end

   // ******************************************
   // state register
   // ******************************************
   always_ff @(posedge clk) begin
      if (!resetn) begin
         // all fields clear first, then the nonzero ones
         cur_reg <= '0;
         cur_reg.state <= EBBS_IDLE;
         // bank compare all ones, turnaround on
         cur_reg.ctlA <= `EBBS_CTL_RESET;
         cur_reg.ctlB <= `EBBS_CTL_RESET;
         cur_reg.progStrobeN <= 1'b1;
         cur_reg.dataStrobeN <= 1'b1;
         cur_reg.ioStrobeN <= 1'b1;
         cur_reg.readStrobeN <= 1'b1;
         cur_reg.writeStrobeN <= 1'b1;
      end else begin
         cur_reg <= cur_next;
      end
   end

   // ******************************************
   // outputs
   // ******************************************
   always_comb begin
      prdata = cur_reg.prdata;
      extAddr = cur_reg.addr;
      extPage = cur_reg.page;
      progStrobeN = cur_reg.progStrobeN;
      dataStrobeN = cur_reg.dataStrobeN;
      ioStrobeN = cur_reg.ioStrobeN;
      readStrobeN = cur_reg.readStrobeN;
      writeStrobeN = cur_reg.writeStrobeN;
      subsystemSelect = cur_reg.subsysSel;
      parallelDataPinsOut = cur_reg.dataOut;
      parallelDataPinsOe = cur_reg.dataOe;
      // keeper only when enabled and the controller does not drive
      keeperLevel = cur_reg.keeperLevel;
      keeperDrive = govCtl[`EBBS_KEEP_BIT] && !cur_reg.dataOe;
      // mode bits of a subsystem frozen while its own copy has the off bit set
      modeLockA = cur_reg.ctlA[`EBBS_OFF_BIT];
      modeLockB = cur_reg.ctlB[`EBBS_OFF_BIT];
      ipiToA = cur_reg.ipiToA;
      ipiToB = cur_reg.ipiToB;
      // level interrupt while an enabled status bit is set
      irq = |(cur_reg.status & cur_reg.irqEn);
   end
endmodule
`default_nettype wire

// ==== tb/ebbs_ext_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
// ******************************************
// external memory on the data pins
// ******************************************
module ebbs_ext_mem (
   input wire logic clk,
   input wire logic readStrobeN,
   input wire logic [15:0] extAddr,
   input wire logic [15:0] parallelDataPinsOut,
   input wire logic parallelDataPinsOe,
   input wire logic [15:0] keeperLevel,
   input wire logic keeperDrive,
   output logic [15:0] parallelDataPinsIn
);
   logic [2:0] holdCnt = 3'h0; // read data hold
   logic [15:0] lastLevel = 16'h0000; // last wire level
   // read answer is the inverted address, held a few cycles
   always @(posedge clk) begin
      if (readStrobeN === 1'b0) holdCnt <= 3'h6;
      else if (holdCnt != 3'h0) holdCnt <= holdCnt - 3'h1;
      lastLevel <= parallelDataPinsIn;
   end
   // wire level from all parties; a released wire toggles
   always_comb begin
      if (parallelDataPinsOe === 1'b1) parallelDataPinsIn = parallelDataPinsOut;
      else if (readStrobeN === 1'b0 || holdCnt != 3'h0) parallelDataPinsIn = ~extAddr;
      else if (keeperDrive === 1'b1) parallelDataPinsIn = keeperLevel;
      else parallelDataPinsIn = ~lastLevel;
   end
endmodule
`default_nettype wire

// ==== tb/ebbs_bank_switch_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ebbs_cfg.svh"
// ******************************************
// port checker
// ******************************************
module ebbs_bank_switch_chk
   import ebbs_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [`EBBS_AW-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ownerB,
   input wire logic reqValid,
   input wire logic reqReady,
   input wire ebbs_pkg::ebbs_space_t reqSpace,
   input wire logic reqRead,
   input wire logic [15:0] reqAddr,
   input wire logic [15:0] reqWrData,
   input wire logic reqSubsys,
   input wire logic [15:0] extAddr,
   input wire logic progStrobeN,
   input wire logic ioStrobeN,
   input wire logic subsystemSelect,
   input wire logic [15:0] parallelDataPinsOut,
   input wire logic parallelDataPinsOe,
   input wire logic keeperDrive,
   input wire logic modeLockA,
   input wire logic ipiToB
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // request taken
   sequence s_acc;
      reqValid && reqReady;
   endsequence
   // bus off held by the governing copy
   sequence s_off_held;
      (modeLockA && !ownerB) [*5];
   endsequence
   a_pready_zero: assert property (psel && penable |-> pready)
      else $error("apb not ready");
   a_slverr_map: assert property (psel && penable && paddr > 12'h010 |-> pslverr)
      else $error("unmapped without error");
   a_io_strobe: assert property (s_acc ##0 reqSpace == EBBS_SP_IO |=> !ioStrobeN && progStrobeN)
      else $error("io strobe missing");
   a_io_select: assert property (s_acc |=> subsystemSelect == $past(reqSubsys))
      else $error("subsystem select wrong");
   a_prog_addr: assert property (s_acc ##0 reqSpace == EBBS_SP_PROG
      |=> !progStrobeN && extAddr == $past(reqAddr))
      else $error("program cycle wrong");
   a_write_drive: assert property (s_acc ##0 !reqRead
      |=> parallelDataPinsOe && parallelDataPinsOut == $past(reqWrData))
      else $error("write data not driven");
   a_keeper_oe: assert property (parallelDataPinsOe |-> !keeperDrive)
      else $error("keeper fights driver");
   a_off_idle: assert property (s_off_held |-> !reqReady && progStrobeN && extAddr == 16'h0000)
      else $error("bus not idle when off");
   a_gap_once: assert property (reqValid && !reqReady && !modeLockA && !ownerB
      |-> ##[1:2] reqReady)
      else $error("gap too long");
   a_ipi_pulse: assert property (ipiToB |=> !ipiToB)
      else $error("interrupt repeated");
endmodule
bind ebbs_bank_switch ebbs_bank_switch_chk chk_u (.clk, .resetn, .psel, .penable, .paddr,
   .pready, .pslverr, .ownerB, .reqValid, .reqReady, .reqSpace, .reqRead, .reqAddr,
   .reqWrData, .reqSubsys, .extAddr, .progStrobeN, .ioStrobeN, .subsystemSelect,
   .parallelDataPinsOut, .parallelDataPinsOe, .keeperDrive, .modeLockA, .ipiToB);
`default_nettype wire

// ==== tb/tb_ebbs_bank_switch.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "ebbs_cfg.svh"
module tb_ebbs_bank_switch;
   import ebbs_pkg::*;
   // ******************************************
   // signals
   // ******************************************
   logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [`EBBS_AW-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ownerB = 1'b0, reqValid = 1'b0, reqReady, er, sio, ssel;
   ebbs_space_t reqSpace = EBBS_SP_PROG;
   logic reqRead = 1'b0, reqSubsys = 1'b0;
   logic [15:0] reqAddr = 16'h0, reqWrData = 16'h0, extAddr, keeperLevel;
   logic [15:0] parallelDataPinsIn, parallelDataPinsOut;
   logic [7:0] reqPage = 8'h00, extPage, spg;
   logic [2:0] sst;
   logic progStrobeN, dataStrobeN, ioStrobeN, readStrobeN, writeStrobeN, subsystemSelect;
   logic parallelDataPinsOe, keeperDrive, modeLockA, modeLockB, ipiToA, ipiToB, irq;
   int badCount = 0, cmpCount = 0, nA = 0, nB = 0, w;
   always #2 clk = ~clk;
   ebbs_bank_switch dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .ownerB, .reqValid, .reqReady, .reqSpace, .reqRead,
      .reqAddr, .reqPage, .reqWrData, .reqSubsys, .extAddr, .extPage, .progStrobeN,
      .dataStrobeN, .ioStrobeN, .readStrobeN, .writeStrobeN, .subsystemSelect,
      .parallelDataPinsIn, .parallelDataPinsOut, .parallelDataPinsOe, .keeperLevel,
      .keeperDrive, .modeLockA, .modeLockB, .ipiToA, .ipiToB, .irq);
   ebbs_ext_mem ext_u (.clk, .readStrobeN, .extAddr, .parallelDataPinsOut,
      .parallelDataPinsOe, .keeperLevel, .keeperDrive, .parallelDataPinsIn);
   // interrupt pulse counters
   always @(posedge clk) begin
      if (ipiToA === 1'b1) nA <= nA + 1;
      if (ipiToB === 1'b1) nB <= nB + 1;
   end
   // ******************************************
   // helpers
   // ******************************************
   task ck(input logic ok, input string m);
      cmpCount++;
      if (ok !== 1'b1) begin
         badCount++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clk);
   endtask
   // one bus request; w counts refused cycles
   task acc(input ebbs_space_t sp, input logic r, input logic [15:0] a,
      input logic [7:0] pg, input logic sb, input int lim);
      @(posedge clk);
      reqValid <= 1'b1;
      reqSpace <= sp;
      reqRead <= r;
      reqAddr <= a;
      reqPage <= pg;
      reqWrData <= ~a;
      reqSubsys <= sb;
      w = 0;
      @(posedge clk);
      while (reqReady !== 1'b1 && w < lim) begin
         w++;
         @(posedge clk);
      end
      reqValid <= 1'b0;
      @(negedge clk);
      sio = ioStrobeN;
      ssel = subsystemSelect;
      sst = {dataStrobeN, readStrobeN, writeStrobeN};
      spg = extPage;
   endtask
   task step(input ebbs_space_t sp, input logic r, input logic [15:0] a,
      input logic [7:0] pg, input int ew);
      acc(sp, r, a, pg, 1'b0, 8);
      ck(w == ew, "gap count");
   endtask
   // ******************************************
   // scenarios
   // ******************************************
   task t_reset;
      apb(1'b0, `EBBS_ADR_CTLA, 32'h0);
      ck(rd === 32'h0000F800, "ctl a reset");
      apb(1'b0, `EBBS_ADR_CTLB, 32'h0);
      ck(rd === 32'h0000F800, "ctl b reset");
      apb(1'b1, `EBBS_ADR_CTLA, 32'h0000FEFA);
      apb(1'b0, `EBBS_ADR_CTLA, 32'h0);
      ck(rd === 32'h0000F800, "reserved bits");
      apb(1'b0, 12'h014, 32'h0);
      ck(er === 1'b1 && rd === 32'h0, "unmapped");
      $display("test reset done");
   endtask
   task t_bank;
      step(EBBS_SP_PROG, 1'b1, 16'h1000, 8'h00, 0);
      step(EBBS_SP_PROG, 1'b1, 16'h1004, 8'h00, 0);
      step(EBBS_SP_PROG, 1'b1, 16'h2000, 8'h00, 1);
      step(EBBS_SP_DATA, 1'b0, 16'h1000, 8'h00, 0);
      step(EBBS_SP_DATA, 1'b0, 16'h3000, 8'h00, 1);
      step(EBBS_SP_PROG, 1'b1, 16'h2000, 8'h01, 1);
      step(EBBS_SP_DATA, 1'b1, 16'h3000, 8'h00, 1);
      step(EBBS_SP_PROG, 1'b1, 16'h2000, 8'h01, 1);
      apb(1'b1, `EBBS_ADR_CTLA, 32'h0);
      step(EBBS_SP_DATA, 1'b1, 16'h8000, 8'h00, 0);
      step(EBBS_SP_PROG, 1'b1, 16'h5000, 8'h01, 0);
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008000);
      step(EBBS_SP_PROG, 1'b1, 16'h7000, 8'h01, 0);
      step(EBBS_SP_PROG, 1'b1, 16'h9000, 8'h01, 1);
      $display("test bank done");
   endtask
   task t_ipi;
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008100);
      repeat (2) @(negedge clk);
      ck(nB == 1 && irq === 1'b0, "ipi masked");
      apb(1'b0, `EBBS_ADR_STAT, 32'h0);
      ck(rd === 32'h1, "status");
      apb(1'b1, `EBBS_ADR_IEN, 32'h7);
      ck(irq === 1'b1, "irq on");
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008100);
      repeat (2) @(negedge clk);
      ck(nB == 1, "no repeat");
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008000);
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008100);
      repeat (2) @(negedge clk);
      ck(nB == 2, "ipi again");
      apb(1'b1, `EBBS_ADR_CLR, 32'h7);
      ck(irq === 1'b0, "irq cleared");
      apb(1'b1, `EBBS_ADR_CTLB, 32'h0000F900);
      repeat (2) @(negedge clk);
      ck(nA == 1 && irq === 1'b1, "ipi to a");
      apb(1'b1, `EBBS_ADR_CLR, 32'h7);
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008000);
      $display("test ipi done");
   endtask
   task t_off;
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008001);
      acc(EBBS_SP_PROG, 1'b1, 16'h4000, 8'h01, 1'b0, 20);
      ck(w == 20 && extAddr === 16'h0 && progStrobeN === 1'b1, "bus off");
      ck(modeLockA === 1'b1 && modeLockB === 1'b0, "mode lock");
      apb(1'b0, `EBBS_ADR_STAT, 32'h0);
      ck(rd[2] === 1'b1 && irq === 1'b1, "off event");
      @(posedge clk);
      ownerB <= 1'b1;
      acc(EBBS_SP_PROG, 1'b1, 16'h4000, 8'h01, 1'b1, 20);
      ck(w < 20 && spg === 8'h01 && sst === 3'b101, "b copy governs");
      @(posedge clk);
      ownerB <= 1'b0;
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008000);
      apb(1'b1, `EBBS_ADR_CLR, 32'h7);
      ck(modeLockA === 1'b0 && irq === 1'b0, "bus on");
      $display("test off done");
   endtask
   task t_io_keep;
      acc(EBBS_SP_IO, 1'b1, 16'hFFFF, 8'h00, 1'b1, 8);
      ck(sio === 1'b0 && ssel === 1'b1 && sst === 3'b101, "io b");
      acc(EBBS_SP_IO, 1'b0, 16'h0000, 8'h00, 1'b0, 8);
      ck(sio === 1'b0 && ssel === 1'b0 && sst === 3'b110, "io a");
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008004);
      acc(EBBS_SP_DATA, 1'b1, 16'h1234, 8'h00, 1'b0, 8);
      ck(w == 1 && sst === 3'b001, "data read");
      repeat (12) @(negedge clk);
      ck(keeperLevel === 16'hEDCB && keeperDrive === 1'b1, "keeper");
      apb(1'b1, `EBBS_ADR_CTLA, 32'h00008000);
      ck(keeperDrive === 1'b0, "keeper off");
      $display("test io keeper done");
   endtask
   // ******************************************
   // run and verdict
   // ******************************************
   task summarize;
      $display("checks %0d mismatches %0d", cmpCount, badCount);
      if (badCount == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_bank;
      t_ipi;
      t_off;
      t_io_keep;
      summarize;
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      summarize;
   end
endmodule
`default_nettype wire
